// >>> cgm_pkg.sv
// Shared constants and types of the clock gate, mux and manager block
package cgm_pkg;
   // ==========================================================
   // Manager measurement and lock
   localparam int PW = 12;
   localparam logic [11:0] PER_MAX = 12'hFFF;
   localparam logic [2:0] LOCK_PERIODS = 3'h4;
   localparam logic [11:0] FX_STOP_LIMIT = 12'hFFF;
   // ==========================================================
   // Status bus bit positions
   localparam int ST_PS_OVF = 0;
   localparam int ST_IN_STOP = 1;
   localparam int ST_FX_STOP = 2;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   // ==========================================================
   // Synthesis and phase shift
   localparam logic [5:0] FX_M_DEFAULT = 6'h04;
   localparam logic [5:0] FX_D_DEFAULT = 6'h01;
   localparam logic signed [9:0] PS_MAX = 10'sh0FF;
   localparam logic [11:0] FINE_RANGE = 12'h040;
   localparam logic [1:0] STEP_LAT = 2'h2;
   localparam logic [4:0] DV_HALF_CODES = 5'h0E;
   localparam logic [5:0] DV_HALF_BASE = 6'h03;
   localparam logic [5:0] DV_INT_BASE = 6'h12;
   // ==========================================================
   // Mux states
   typedef enum logic {
      MX_RUN = 1'b0,
      MX_HOLD = 1'b1
   } cgm_mux_state_t;

   // Divide code to ratio in half units: 0..13 -> 1.5..8, 14..21 -> 9..16
   function automatic logic [5:0] dv_half(input logic [4:0] code);
      logic [5:0] c;
      c = {1'b0, code};
      if (code < DV_HALF_CODES) begin
         return c + DV_HALF_BASE;
      end
      return DV_INT_BASE + 6'((c - {1'b0, DV_HALF_CODES}) << 1);
   endfunction
endpackage

// >>> cgm_gate.sv
// Gated global buffer: passes or suppresses whole input pulses
module cgm_gate (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   // Gate
   input wire logic i_clock_in,
   input wire logic i_enable,
   input wire logic i_falling,
   output logic o_clock
);
   logic [1:0] s1, s2;
   logic prev, pass, next_prev, next_pass, next_o, lvl, rise;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s1 <= 2'h0;
         s2 <= 2'h0;
      end else if (i_ce) begin
         s1 <= {i_enable, i_clock_in};
         s2 <= s1;
      end
   end

   // ==========================================================
   // Pulse decision
   always_comb begin
      lvl = s2[0] ^ i_falling;
      rise = lvl & ~prev;
      next_prev = lvl;
      // Enable only matters at the start of a pulse
      next_pass = rise ? s2[1] : pass;
      next_o = (lvl & next_pass) ^ i_falling;
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         prev <= 1'b0;
         pass <= 1'b0;
         o_clock <= 1'b0;
      end else if (i_ce) begin
         prev <= next_prev;
         pass <= next_pass;
         o_clock <= next_o;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst || !i_ce);

   a_gate_pass: assert property (rise && s2[1] && !i_falling |=> o_clock)
      else $error("gate did not pass enabled pulse");
   a_gate_block: assert property (rise && !s2[1] && !i_falling ##1 lvl |-> !o_clock)
      else $error("gate passed disabled pulse");
   a_gate_hold: assert property (!rise && lvl && !i_falling |=> o_clock == $past(pass))
      else $error("enable change during high altered output");
endmodule // cgm_gate

// >>> cgm_mux.sv
// Glitch-free two-input clock multiplexer
module cgm_mux (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   // Mux
   input wire logic i_in0,
   input wire logic i_in1,
   input wire logic i_sel,
   input wire logic i_falling,
   output logic o_clock
);
   logic [2:0] s1, s2;
   logic [1:0] prev, lvl;
   logic cur, next_cur, next_o, new_fall;
   cgm_pkg::cgm_mux_state_t state, next_state;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s1 <= 3'h0;
         s2 <= 3'h0;
      end else if (i_ce) begin
         s1 <= {i_sel, i_in1, i_in0};
         s2 <= s1;
      end
   end

   // ==========================================================
   // Switchover
   always_comb begin
      lvl = s2[1:0] ^ {2{i_falling}};
      new_fall = prev[~cur] & ~lvl[~cur];
      next_state = state;
      next_cur = cur;
      next_o = 1'b0;
      case (state)
         cgm_pkg::MX_RUN: begin
            next_o = lvl[cur];
            // Old clock high: select change waits for its fall
            if (s2[2] != cur && !lvl[cur]) begin
               next_state = cgm_pkg::MX_HOLD;
               next_o = 1'b0;
            end
         end
         cgm_pkg::MX_HOLD: begin
            // Low until the new clock falls, so no phase is cut short
            if (new_fall) begin
               next_cur = ~cur;
               next_state = cgm_pkg::MX_RUN;
            end
         end
         default: next_state = cgm_pkg::MX_RUN;
      endcase
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         prev <= 2'h0;
         cur <= 1'b0;
         state <= cgm_pkg::MX_RUN;
         o_clock <= 1'b0;
      end else if (i_ce) begin
         prev <= lvl;
         cur <= next_cur;
         state <= next_state;
         o_clock <= next_o ^ i_falling;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst || !i_ce);

   sequence s_enter_hold;
      state == cgm_pkg::MX_RUN && s2[2] != cur && !lvl[cur];
   endsequence
   a_mux_hold_low: assert property (state == cgm_pkg::MX_HOLD && !i_falling |=> !o_clock)
      else $error("mux output not low while switching");
   a_mux_enter: assert property (s_enter_hold ##1 !i_falling |-> state == cgm_pkg::MX_HOLD)
      else $error("mux did not start switchover");
   a_mux_route: assert property (state == cgm_pkg::MX_RUN && s2[2] == cur && !i_falling
      |=> o_clock == $past(lvl[cur]))
      else $error("mux output not following selected input");
endmodule // cgm_mux

// >>> cgm_top.sv
// Clock gate, glitch-free clock mux and clock manager, sampled on the core clock
//
// Contract
// - Enable high before rise passes whole pulse.
// - Enable low before rise suppresses pulse, low.
// - Select low routes input zero, high one.
// - Switchover never produces shorter phases.
// - Select change waits while current clock high.
// - Output low until new clock falls.
// - Falling variant swaps edges and levels.
// - Manager reset clears all manager circuits; the phase shift instead reloads i_phase_shift_setting.
// - Lock high only when enabled circuits locked.
// - Status bits: overflow, input stopped, fx stopped.
// - Doubled, synthesized outputs with inverted twins.
// - Divide 1.5 to 8 halves, 9 to 16.
// - Synthesized frequency is input times M/D.
// - Duty 50/50, except odd-half divide high-freq.
// - High-freq drops doubled, quarter outputs; quarter spacing.
// - Fine shift offsets by setting/256 of period.
// - Shift setting spans -255 to +255.
// - Variable mode halves delay range each way.
// - Phase step with direction on step clock.
module cgm_top #(
   parameter logic [5:0] FX_MULTIPLY = cgm_pkg::FX_M_DEFAULT,
   parameter logic [5:0] FX_DIVIDE = cgm_pkg::FX_D_DEFAULT
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   // Gated global buffer
   input wire logic i_gate_clock,
   input wire logic i_gate_enable,
   input wire logic i_gate_falling,
   output logic o_gated_global_buffer,
   // Glitch-free clock mux
   input wire logic i_mux_input_zero,
   input wire logic i_mux_input_one,
   input wire logic i_mux_select,
   input wire logic i_mux_falling,
   output logic o_glitchfree_clock_mux,
   // Manager configuration
   input wire logic i_manager_reset,
   input wire logic i_feedback_used,
   input wire logic i_high_freq,
   input wire logic i_variable_mode,
   input wire logic [8:0] i_phase_shift_setting,
   input wire logic [4:0] i_divide_ratio_setting,
   // Manager clocks and phase step
   input wire logic i_manager_input_clock,
   input wire logic i_feedback_input,
   input wire logic i_phase_step_clock,
   input wire logic i_phase_step_enable,
   input wire logic i_step_direction,
   // Manager outputs
   output logic o_zero_degree_output,
   output logic o_quarter_phase_output,
   output logic o_half_phase_output,
   output logic o_three_quarter_phase_output,
   output logic o_doubled_output,
   output logic o_doubled_output_inverted,
   output logic o_divided_output,
   output logic o_synthesized_output,
   output logic o_synthesized_output_inverted,
   output logic o_locked,
   output logic [7:0] o_status,
   output logic o_step_complete
);
   // ==========================================================
   // Gate and mux
   cgm_gate u_gate (
      .i_clk(i_core_clk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_clock_in(i_gate_clock),
      .i_enable(i_gate_enable),
      .i_falling(i_gate_falling),
      .o_clock(o_gated_global_buffer)
   );

   cgm_mux u_mux (
      .i_clk(i_core_clk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_in0(i_mux_input_zero),
      .i_in1(i_mux_input_one),
      .i_sel(i_mux_select),
      .i_falling(i_mux_falling),
      .o_clock(o_glitchfree_clock_mux)
   );

   // Wraps a signed position into 0..p-1, for v from -p up to 3p-1
   function automatic logic [11:0] wrap(input logic signed [14:0] v, input logic [11:0] p);
      logic signed [14:0] r;
      logic signed [14:0] sp;
      r = v;
      sp = $signed({3'h0, p});
      if (r < 0) r = r + sp;
      if (r >= sp) r = r - sp;
      if (r >= sp) r = r - sp;
      return r[11:0];
   endfunction

   // ==========================================================
   // Synchronisers: clock in, feedback, step clock, enable, direction
   logic [4:0] s1, s2, s3;
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         s1 <= 5'h00;
         s2 <= 5'h00;
         s3 <= 5'h00;
      end else if (i_ce) begin
         s1 <= {i_step_direction, i_phase_step_enable, i_phase_step_clock, i_feedback_input,
                i_manager_input_clock};
         s2 <= s1;
         s3 <= s2;
      end
   end

   logic in_rise, fb_rise, ps_rise;
   assign in_rise = s2[0] & ~s3[0];
   assign fb_rise = s2[1] & ~s3[1];
   assign ps_rise = s2[2] & ~s3[2];

   // ==========================================================
   // Manager state
   logic [11:0] per_cnt, period, t, comp, fx_idle;
   logic [2:0] stable;
   logic in_stop, fb_ok, ovf, fx_stop, busy, done;
   logic signed [8:0] ps;
   logic [1:0] step_cnt;
   logic [17:0] dv_cnt, fx_acc;
   logic [11:0] next_per_cnt, next_period, next_t, next_comp, next_fx_idle;
   logic [2:0] next_stable;
   logic next_in_stop, next_fb_ok, next_ovf, next_fx_stop, next_busy, next_done;
   logic signed [8:0] next_ps;
   logic [1:0] next_step_cnt;
   logic [17:0] next_dv_cnt, next_fx_acc;
   logic next_zero, next_quarter, next_dbl, next_dv, next_fx, next_locked;
   logic [7:0] next_status;

   // Derived phase terms
   logic signed [21:0] prod;
   logic signed [12:0] off, abs_off;
   logic signed [9:0] ps_try;
   logic [11:0] ph, ph_q, ph2, half, lim, e;
   logic [5:0] h;
   logic [17:0] hp, hm, dv_len, dv_high, fx_len, fx_sum;
   logic run, grow;

   always_comb begin
      prod = ps * $signed({10'h000, period});
      off = prod[20:8];
      abs_off = off[12] ? -off : off;
      half = period >> 1;
      ph = wrap($signed({3'h0, t}) + $signed({3'h0, comp}) - {{2{off[12]}}, off}, period);
      ph_q = wrap($signed({3'h0, ph}) - $signed({3'h0, period >> 2}), period);
      ph2 = (ph >= half) ? ph - half : ph;
      h = cgm_pkg::dv_half(i_divide_ratio_setting);
      hp = {12'h000, h} * {6'h00, period};
      hm = hp - {6'h00, period};
      dv_len = {1'b0, hp[17:1]};
      // Odd half ratios in high-freq mode give K/(2K+1) high time
      dv_high = (i_high_freq && h[0]) ? {2'h0, hm[17:2]} : {2'h0, hp[17:2]};
      fx_len = {12'h000, FX_DIVIDE} * {6'h00, period};
      fx_sum = fx_acc + {12'h000, FX_MULTIPLY};
      // Variable mode centres zero skew, halving reach
      lim = i_variable_mode ? (cgm_pkg::FINE_RANGE >> 1) : cgm_pkg::FINE_RANGE;
      ps_try = s2[4] ? 10'(ps) + 10'sh001 : 10'(ps) - 10'sh001;
      grow = s2[4] ? (ps >= 0) : (ps <= 0);
      e = wrap($signed({3'h0, t}) - {{2{off[12]}}, off}, period);
      run = (period != 12'h000) && !in_stop;
   end

   always_comb begin
      next_per_cnt = per_cnt;
      next_period = period;
      next_t = t;
      next_comp = comp;
      next_stable = stable;
      next_in_stop = in_stop;
      next_fb_ok = fb_ok;
      next_ovf = ovf;
      next_ps = ps;
      next_busy = busy;
      next_done = done;
      next_step_cnt = step_cnt;
      next_dv_cnt = dv_cnt;
      next_fx_acc = fx_acc;
      next_fx_idle = fx_idle;
      next_fx_stop = fx_stop;
      next_zero = 1'b0;
      next_quarter = 1'b0;
      next_dbl = 1'b0;
      next_dv = 1'b0;
      next_fx = 1'b0;
      next_locked = 1'b0;
      next_status = cgm_pkg::STATUS_RESET;
      if (i_manager_reset) begin
         // Every manager circuit restarts
         next_per_cnt = 12'h000;
         next_period = 12'h000;
         next_t = 12'h000;
         next_comp = 12'h000;
         next_stable = 3'h0;
         next_in_stop = 1'b0;
         next_fb_ok = 1'b0;
         next_ovf = 1'b0;
         next_ps = $signed(i_phase_shift_setting);
         next_busy = 1'b0;
         next_done = 1'b0;
         next_step_cnt = 2'h0;
         next_dv_cnt = 18'h00000;
         next_fx_acc = 18'h00000;
         next_fx_idle = 12'h000;
         next_fx_stop = 1'b0;
      end else begin
         // Period measurement and stop detection
         if (in_rise) begin
            next_per_cnt = 12'h001;
            next_period = per_cnt;
            next_t = 12'h000;
            next_in_stop = 1'b0;
            if (per_cnt != period) next_stable = 3'h0;
            else if (stable != cgm_pkg::LOCK_PERIODS) next_stable = stable + 3'h1;
         end else if (per_cnt == cgm_pkg::PER_MAX) begin
            next_in_stop = 1'b1;
            next_stable = 3'h0;
         end else begin
            next_per_cnt = per_cnt + 12'h001;
            next_t = (t + 12'h001 >= period) ? 12'h000 : t + 12'h001;
         end
         // De-skew: walk compensation until feedback meets target
         if (fb_rise && i_feedback_used) begin
            next_fb_ok = (e == 12'h000);
            if (e != 12'h000 && e < half) next_comp = wrap($signed({3'h0, comp}) + 15'sh0001, period);
            else if (e != 12'h000) next_comp = wrap($signed({3'h0, comp}) - 15'sh0001, period);
         end
         // Variable-mode stepping on the step clock
         if (ps_rise) begin
            if (busy) begin
               next_step_cnt = step_cnt + 2'h1;
               if (step_cnt == cgm_pkg::STEP_LAT) begin
                  next_done = 1'b1;
                  next_busy = 1'b0;
               end
            end else begin
               next_done = 1'b0;
               if (s2[3] && i_variable_mode) begin
                  next_busy = 1'b1;
                  next_step_cnt = 2'h1;
                  // Refused steps leave the shift and flag overflow
                  if (ps_try > cgm_pkg::PS_MAX || ps_try < -cgm_pkg::PS_MAX
                      || (abs_off >= $signed({1'b0, lim}) && grow)) begin
                     next_ovf = 1'b1;
                  end else begin
                     next_ovf = 1'b0;
                     next_ps = ps_try[8:0];
                  end
               end
            end
         end
         // Synthesized clock by accumulator; stalls with the input
         if (run) begin
            next_fx_acc = (fx_sum >= fx_len) ? fx_sum - fx_len : fx_sum;
            next_dv_cnt = (dv_cnt + 18'h00001 >= dv_len) ? 18'h00000 : dv_cnt + 18'h00001;
         end
         next_fx = run && (next_fx_acc < (fx_len >> 1));
         if (next_fx != o_synthesized_output) next_fx_idle = 12'h000;
         else if (fx_idle != cgm_pkg::FX_STOP_LIMIT) next_fx_idle = fx_idle + 12'h001;
         next_fx_stop = (fx_idle == cgm_pkg::FX_STOP_LIMIT);
         // Coarse phases a quarter period apart
         next_zero = run && (ph < half);
         next_quarter = run && !i_high_freq && (ph_q < half);
         next_dbl = run && !i_high_freq && (ph2 < (half >> 1));
         next_dv = run && (dv_cnt < dv_high);
         next_locked = (stable == cgm_pkg::LOCK_PERIODS) && !next_in_stop
                       && (!i_feedback_used || fb_ok);
         next_status[cgm_pkg::ST_PS_OVF] = next_ovf;
         next_status[cgm_pkg::ST_IN_STOP] = next_in_stop;
         next_status[cgm_pkg::ST_FX_STOP] = next_fx_stop;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         per_cnt <= 12'h000;
         period <= 12'h000;
         t <= 12'h000;
         comp <= 12'h000;
         stable <= 3'h0;
         in_stop <= 1'b0;
         fb_ok <= 1'b0;
         ovf <= 1'b0;
         ps <= 9'sh000;
         busy <= 1'b0;
         done <= 1'b0;
         step_cnt <= 2'h0;
         dv_cnt <= 18'h00000;
         fx_acc <= 18'h00000;
         fx_idle <= 12'h000;
         fx_stop <= 1'b0;
         o_zero_degree_output <= 1'b0;
         o_half_phase_output <= 1'b0;
         o_quarter_phase_output <= 1'b0;
         o_three_quarter_phase_output <= 1'b0;
         o_doubled_output <= 1'b0;
         o_doubled_output_inverted <= 1'b0;
         o_divided_output <= 1'b0;
         o_synthesized_output <= 1'b0;
         o_synthesized_output_inverted <= 1'b0;
         o_locked <= 1'b0;
         o_status <= cgm_pkg::STATUS_RESET;
         o_step_complete <= 1'b0;
      end else if (i_ce) begin
         per_cnt <= next_per_cnt;
         period <= next_period;
         t <= next_t;
         comp <= next_comp;
         stable <= next_stable;
         in_stop <= next_in_stop;
         fb_ok <= next_fb_ok;
         ovf <= next_ovf;
         ps <= next_ps;
         busy <= next_busy;
         done <= next_done;
         step_cnt <= next_step_cnt;
         dv_cnt <= next_dv_cnt;
         fx_acc <= next_fx_acc;
         fx_idle <= next_fx_idle;
         fx_stop <= next_fx_stop;
         o_zero_degree_output <= next_zero;
         o_half_phase_output <= run && !next_zero && !i_manager_reset;
         o_quarter_phase_output <= next_quarter;
         o_three_quarter_phase_output <= run && !i_high_freq && !next_quarter && !i_manager_reset;
         o_doubled_output <= next_dbl;
         o_doubled_output_inverted <= run && !i_high_freq && !next_dbl && !i_manager_reset;
         o_divided_output <= next_dv;
         o_synthesized_output <= next_fx;
         o_synthesized_output_inverted <= run && !next_fx && !i_manager_reset;
         o_locked <= next_locked;
         o_status <= next_status;
         o_step_complete <= next_done;
      end
   end

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst || !i_ce);

   a_mgr_reset_clear: assert property (i_manager_reset |=> !o_locked && o_status == 8'h00)
      else $error("manager reset left lock or status set");
   a_lock_no_stop: assert property (o_locked |-> !o_status[1])
      else $error("locked while input stopped");
   a_status_unused: assert property (o_status[7:3] == 5'h00)
      else $error("unused status bits set");
   a_ps_range: assert property (ps <= 9'sh0FF && ps >= -9'sh0FF)
      else $error("phase shift out of range");
   a_hf_no_double: assert property (i_high_freq |=> !o_doubled_output && !o_quarter_phase_output)
      else $error("high-freq output not suppressed");
   a_step_hold: assert property (o_step_complete && !ps_rise && !i_manager_reset |=> o_step_complete)
      else $error("step pulse shorter than one step clock");
   a_step_drop: assert property (o_step_complete && ps_rise && !busy |=> !o_step_complete)
      else $error("step pulse longer than one step clock");
   a_fx_twin: assert property (run && !i_manager_reset |=>
      o_synthesized_output_inverted == !o_synthesized_output)
      else $error("synthesized twin not inverted");
endmodule // cgm_top

// >>> cgm_fabric.sv
// Fabric-side model: makes the slow clocks that feed the block
module cgm_fabric (
   // Clock and control
   input wire logic i_core_clk,
   input wire logic i_stop,
   // Generated clocks
   output logic o_gate_clk,
   output logic o_in0,
   output logic o_in1,
   output logic o_mgr_clk,
   output logic o_ps_clk
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] cnt = 8'h00;
   logic [4:0] c20 = 5'h00;
   // Off the falling edge, so the core samples settled levels
   always @(negedge i_core_clk) begin
      cnt <= cnt + 8'h01;
      c20 <= (c20 == 5'h13) ? 5'h00 : c20 + 5'h01;
   end
   // Mux inputs unrelated: periods 8 and 20 cycles
   assign o_gate_clk = cnt[3];
   assign o_in0 = cnt[2];
   assign o_in1 = (c20 >= 5'h0A);
   assign o_ps_clk = cnt[2];
   // Stopped input clock rests low
   assign o_mgr_clk = cnt[4] & ~i_stop;
endmodule // cgm_fabric

// >>> tb_cgm_top.sv
// Self-checking bench of the clock gate, mux and manager
module tb_cgm_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_core_clk = 1'b0, i_rst = 1'b1, gen = 1'b0, sel = 1'b0, mrst = 1'b0, vmode = 1'b1, phase_step_enable = 1'b0;
   logic dir = 1'b1, stop = 1'b0, watch = 1'b0, seen_hi = 1'b0, hf = 1'b0;
   logic gclk, in0, in1, mclk, phase_step_clock, o_gate, o_mux, o_zero, o_dbl, o_div, o_fx, o_lock, o_done;
   logic oq1, oq2, oq3, o_dbli, o_fxi;
   logic [4:0] dv = 5'h02;
   logic [7:0] o_status;
   logic [10:0] mon;
   // Rises per 320 cycles with a 32-cycle input: fx x4, doubled x2, coarse x1, divide 2.5
   int exp_r [2:10] = '{40, 20, 10, 4, 10, 10, 10, 20, 40};
   int errors = 0, tests_run = 0, n, cycles = 0;
   always #20 i_core_clk = ~i_core_clk;
   assign mon = {o_fxi, o_dbli, oq3, oq2, oq1, o_div, o_zero, o_dbl, o_fx, o_mux, o_gate};
   cgm_fabric i_cgm_fabric (.i_core_clk(i_core_clk), .i_stop(stop), .o_gate_clk(gclk), .o_in0(in0),
      .o_in1(in1), .o_mgr_clk(mclk), .o_ps_clk(phase_step_clock));
   cgm_top i_cgm_top (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(1'b1), .i_gate_clock(gclk),
      .i_gate_enable(gen), .i_gate_falling(1'b0), .o_gated_global_buffer(o_gate), .i_mux_input_zero(in0),
      .i_mux_input_one(in1), .i_mux_select(sel), .i_mux_falling(1'b0), .o_glitchfree_clock_mux(o_mux),
      .i_manager_reset(mrst), .i_feedback_used(1'b0), .i_high_freq(hf), .i_variable_mode(vmode),
      .i_phase_shift_setting(9'h000), .i_divide_ratio_setting(dv), .i_manager_input_clock(mclk),
      .i_feedback_input(o_zero), .i_phase_step_clock(phase_step_clock), .i_phase_step_enable(phase_step_enable),
      .i_step_direction(dir), .o_zero_degree_output(o_zero), .o_quarter_phase_output(oq1),
      .o_half_phase_output(oq2), .o_three_quarter_phase_output(oq3), .o_doubled_output(o_dbl),
      .o_doubled_output_inverted(o_dbli), .o_divided_output(o_div), .o_synthesized_output(o_fx),
      .o_synthesized_output_inverted(o_fxi), .o_locked(o_lock), .o_status(o_status), .o_step_complete(o_done));
   // ==========================================================
   // Helpers
   // Sampled off the launching edge, so outputs are settled
   always @(negedge i_core_clk) begin
      if (watch && o_mux) seen_hi <= 1'b1;
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors = errors + 1;
         tally_and_finish();
      end
   end
   task automatic cyc(input int k);
      repeat (k) @(negedge i_core_clk);
   endtask
   task automatic chk_val(input logic [7:0] exp, input logic [7:0] act);
      tests_run++;
      if (act !== exp) begin
         errors++;
         $display("mismatch at %0t exp %h got %h", $time, exp, act);
      end
   endtask
   // Frequency counts may straddle one edge at a window boundary
   task automatic chk_cnt(input int exp, input int act);
      tests_run++;
      if (act < exp - 1 || act > exp + 1) begin
         errors++;
         $display("mismatch at %0t exp %h got %h", $time, exp, act);
      end
   endtask
   task automatic rises(input int k, input int len, output int cnt);
      logic p;
      cnt = 0;
      p = mon[k];
      repeat (len) begin
         @(negedge i_core_clk);
         if (mon[k] && !p) cnt++;
         p = mon[k];
      end
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ==========================================================
   // Tests
   initial begin
      cyc(4);
      i_rst = 1'b0;
      chk_val(8'h00, {o_status[7:1], o_lock});
      mrst = 1'b1;
      cyc(2);
      mrst = 1'b0;
      for (int e = 1; e >= 0; e--) begin
         @(negedge gclk);
         cyc(2);
         gen = e[0];
         rises(0, 64, n);
         chk_val(8'(e * 4), 8'(n));
      end
      $display("test gate done");
      @(negedge in0);
      cyc(2);
      rises(1, 64, n);
      chk_val(8'h08, 8'(n));
      @(negedge in0);
      sel = 1'b1;
      cyc(4);
      watch = 1'b1;
      @(negedge in1);
      cyc(2);
      watch = 1'b0;
      chk_val(8'h00, {7'h00, seen_hi});
      rises(1, 80, n);
      chk_val(8'h04, 8'(n));
      $display("test mux done");
      for (n = 0; n < 600 && o_lock !== 1'b1; n++) cyc(1);
      chk_val(8'h01, {7'h00, o_lock});
      chk_val(8'h00, o_status);
      for (int k = 2; k <= 10; k++) begin
         rises(k, 320, n);
         chk_cnt(exp_r[k], n);
      end
      hf = 1'b1;
      dv = 5'h00;
      cyc(100);
      rises(3, 320, n);
      chk_val(8'h00, 8'(n));
      rises(6, 320, n);
      chk_val(8'h00, 8'(n));
      // Divide 1.5 in high-freq mode: 16 high cycles of 48
      n = 0;
      repeat (48) begin
         cyc(1);
         if (mon[5] === 1'b1) n++;
      end
      chk_val(8'h10, 8'(n));
      hf = 1'b0;
      dv = 5'h02;
      $display("test manager done");
      for (int d = 1; d >= 0; d--) begin
         @(negedge phase_step_clock);
         phase_step_enable = 1'b1;
         dir = d[0];
         @(negedge phase_step_clock);
         phase_step_enable = 1'b0;
         for (n = 0; n < 60 && o_done !== 1'b1; n++) cyc(1);
         for (n = 0; n < 60 && o_done === 1'b1; n++) cyc(1);
         chk_val(8'h08, 8'(n));
         chk_val(8'h00, {7'h00, o_status[0]});
      end
      $display("test step done");
      stop = 1'b1;
      cyc(4140);
      chk_val(8'h02, {5'h00, o_status[2:1], o_lock});
      cyc(4140);
      chk_val(8'h06, {5'h00, o_status[2:1], o_lock});
      stop = 1'b0;
      mrst = 1'b1;
      cyc(2);
      chk_val(8'h00, o_status);
      mrst = 1'b0;
      $display("test stop done");
      tally_and_finish();
   end
endmodule // tb_cgm_top
